/* File: rtl/cpuod_pkg.sv */
// package: constants and carrier types for the operand and condition decoder
package cpuod_pkg;

  // apb register map
  localparam logic [11:0] CPUOD_OFF_OPC     = 12'h000;
  localparam logic [11:0] CPUOD_OFF_OPND    = 12'h004;
  localparam logic [11:0] CPUOD_OFF_FLAGS   = 12'h008;
  localparam logic [11:0] CPUOD_OFF_PC      = 12'h00C;
  localparam logic [11:0] CPUOD_OFF_RP      = 12'h010;
  localparam logic [11:0] CPUOD_OFF_BASE    = 12'h014;
  localparam logic [11:0] CPUOD_OFF_JUMP    = 12'h018;
  localparam logic [11:0] CPUOD_OFF_ADDR    = 12'h01C;
  localparam logic [11:0] CPUOD_OFF_ADC     = 12'h020;
  localparam logic [11:0] CPUOD_OFF_FIELDS  = 12'h024;

  // flags register bit positions
  localparam int CPUOD_FLAG_C = 7;
  localparam int CPUOD_FLAG_Z = 6;
  localparam int CPUOD_FLAG_S = 5;
  localparam int CPUOD_FLAG_V = 4;
  localparam int CPUOD_FLAG_D = 3;
  localparam int CPUOD_FLAG_H = 2;

  // opcode fields
  localparam int CPUOD_CC_HI   = 7;
  localparam int CPUOD_CC_LO   = 4;
  localparam logic [3:0] CPUOD_OPC_JP_LO = 4'hD;
  localparam logic [3:0] CPUOD_OPC_JR_LO = 4'hB;
  localparam logic [7:0] CPUOD_OPC_ADD_RR  = 8'h04;
  localparam logic [7:0] CPUOD_OPC_ADC_RR  = 8'h12;
  localparam logic [7:0] CPUOD_OPC_ADC_RIR = 8'h13;
  localparam logic [3:0] CPUOD_ESC_NIBBLE  = 4'hE;

  // reset values
  localparam logic [7:0]  CPUOD_RST_BYTE = 8'h00;
  localparam logic [15:0] CPUOD_RST_WORD = 16'h0000;

  // condition selector codes
  typedef enum logic [3:0] {
    CPUOD_CC_NEVER  = 4'h0, CPUOD_CC_SLT = 4'h1, CPUOD_CC_SLE = 4'h2, CPUOD_CC_ULE = 4'h3,
    CPUOD_CC_OVS    = 4'h4, CPUOD_CC_NEG = 4'h5, CPUOD_CC_ZS  = 4'h6, CPUOD_CC_CS  = 4'h7,
    CPUOD_CC_ALWAYS = 4'h8, CPUOD_CC_SGE = 4'h9, CPUOD_CC_SGT = 4'hA, CPUOD_CC_UGT = 4'hB,
    CPUOD_CC_OVC    = 4'hC, CPUOD_CC_POS = 4'hD, CPUOD_CC_ZC  = 4'hE, CPUOD_CC_CC  = 4'hF
  } cpuod_cc_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } cpuod_flags_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } cpuod_instr_t;

  typedef struct packed {
    cpuod_instr_t instr;
    cpuod_flags_t flags;
    logic [15:0]  next_pc;
    logic [7:0]   reg_ptr;
    logic [15:0]  base;
    logic [7:0]   adc_dst;
    logic [7:0]   adc_src;
    logic         is_cond;
    logic         taken;
    logic [15:0]  target;
    logic [7:0]   src_reg;
    logic [7:0]   dst_reg;
    logic [11:0]  ext_addr;
    logic [15:0]  index_addr;
    logic [7:0]   adc_sum;
    cpuod_flags_t adc_flags;
    logic [31:0]  rdata;
    logic         slverr;
  } cpuod_state_t;

endpackage : cpuod_pkg

/* File: rtl/cpuod_decode.sv */
// operand field and condition selector decoder with apb register access
//
// What this block does
// - condition selector is opcode bits 7:4
// - jump taken only when selected test true
// - 0000 never jumps, 1000 always jumps
// - signed tests and their complements
// - unsigned carry/zero tests
// - single-flag overflow, sign, zero tests
// - aliased condition names decode identically
// - opcode 04 bytes are source then destination
// - byte Ex escapes to working register x
// - extended register address is 12 bits
// - direct program address is 16 bits
// - relative displacement signed, from next instruction
// - indexed location is base plus signed index; the code clears base bit 0 before adding
// - register pairs even, working pairs 0..14
// - bit number is a 3-bit field
// - polarity is a single bit value
// - immediate byte spans 00..FF
// - trap vector is an 8-bit value
// - add with carry, opcodes 12 and 13
//
// Decided for this implementation: the address map and register access over APB.
module cpuod_decode
  import cpuod_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             jump_taken,
  output logic      [15:0] jump_target
);

  cpuod_state_t state;
  cpuod_state_t next_state;

  logic        wr_en;
  logic        rd_en;
  logic [3:0]  condition_selector;
  logic        cond_true;
  logic        sxv;
  logic [7:0]  immediate_byte;
  logic [7:0]  relative_displacement;
  logic [15:0] direct_program_address;
  logic [11:0] extended_register_address;
  logic [2:0]  bit_number;
  logic        polarity;
  logic [7:0]  trap_vector;
  logic [8:0]  adc_wide;
  logic [4:0]  adc_low;
  logic        adc_ovf;

  // escaped byte Ex names working register x via the register pointer
  function automatic logic [7:0] cpuod_reg8(input logic [7:0] b, input logic [7:0] rp);
    if (b[7:4] == CPUOD_ESC_NIBBLE) begin
      cpuod_reg8 = {rp[7:4], b[3:0]};
    end else begin
      cpuod_reg8 = b;
    end
  endfunction : cpuod_reg8

  function automatic logic [7:0] cpuod_merge(input logic [7:0] old, input logic [7:0] nw,
                                             input logic ln);
    cpuod_merge = ln ? nw : old;
  endfunction : cpuod_merge

  // every apb access completes in its first access cycle
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign prdata  = state.rdata;
  assign pslverr = state.slverr;
  assign jump_taken  = state.taken;
  assign jump_target = state.target;

  always_comb begin
    next_state = state;
    condition_selector = state.instr.opcode[CPUOD_CC_HI:CPUOD_CC_LO];
    sxv = state.flags.s ^ state.flags.v;
    // one test per selector; aliased names share a code so nothing extra needed
    unique case (cpuod_cc_t'(condition_selector))
      CPUOD_CC_NEVER:  cond_true = 1'b0;
      CPUOD_CC_ALWAYS: cond_true = 1'b1;
      CPUOD_CC_SLT:    cond_true = sxv;
      CPUOD_CC_SLE:    cond_true = state.flags.z | sxv;
      CPUOD_CC_SGE:    cond_true = ~sxv;
      CPUOD_CC_SGT:    cond_true = ~(state.flags.z | sxv);
      CPUOD_CC_ULE:    cond_true = state.flags.c | state.flags.z;
      CPUOD_CC_CS:     cond_true = state.flags.c;
      CPUOD_CC_UGT:    cond_true = ~state.flags.c & ~state.flags.z;
      CPUOD_CC_CC:     cond_true = ~state.flags.c;
      CPUOD_CC_OVS:    cond_true = state.flags.v;
      CPUOD_CC_NEG:    cond_true = state.flags.s;
      CPUOD_CC_ZS:     cond_true = state.flags.z;
      CPUOD_CC_OVC:    cond_true = ~state.flags.v;
      CPUOD_CC_POS:    cond_true = ~state.flags.s;
      CPUOD_CC_ZC:     cond_true = ~state.flags.z;
    endcase

    // operand fields, all full range of their width
    immediate_byte            = state.instr.byte1;
    trap_vector               = state.instr.byte1;
    relative_displacement     = state.instr.byte1;
    direct_program_address    = {state.instr.byte1, state.instr.byte2};
    extended_register_address = {state.instr.byte1[3:0], state.instr.byte2};
    bit_number                = state.instr.byte1[3:1];
    polarity                  = state.instr.byte1[7];

    // flags are the registered values last written through the flags register
    next_state.is_cond = (state.instr.opcode[3:0] == CPUOD_OPC_JP_LO) ||
                         (state.instr.opcode[3:0] == CPUOD_OPC_JR_LO);
    next_state.taken = next_state.is_cond && cond_true;
    if (state.instr.opcode[3:0] == CPUOD_OPC_JR_LO) begin
      // next_pc already points past the jump
      next_state.target = state.next_pc + {{8{relative_displacement[7]}},
                                           relative_displacement};
    end else if (state.instr.opcode[3:0] == CPUOD_OPC_JP_LO) begin
      next_state.target = direct_program_address;
    end else begin
      next_state.target = state.next_pc;
    end
    if (!next_state.taken) begin
      next_state.target = state.next_pc;
    end

    // object code for opcode 04 carries source first
    if (state.instr.opcode == CPUOD_OPC_ADD_RR) begin
      next_state.src_reg = cpuod_reg8(state.instr.byte1, state.reg_ptr);
      next_state.dst_reg = cpuod_reg8(state.instr.byte2, state.reg_ptr);
    end else begin
      next_state.src_reg = cpuod_reg8(state.instr.byte1, state.reg_ptr);
      next_state.dst_reg = cpuod_reg8(state.instr.byte2, state.reg_ptr);
    end
    next_state.ext_addr = extended_register_address;
    // pair operands force even: the base has bit 0 cleared before the signed index is added
    next_state.index_addr = {state.base[15:1], 1'b0} +
                            {{8{state.instr.byte3[7]}}, state.instr.byte3};

    // add with carry on the two operand bytes held in the adc register
    adc_wide = {1'b0, state.adc_dst} + {1'b0, state.adc_src} + {8'h00, state.flags.c};
    adc_low  = {1'b0, state.adc_dst[3:0]} + {1'b0, state.adc_src[3:0]} +
               {4'h0, state.flags.c};
    adc_ovf  = (state.adc_dst[7] == state.adc_src[7]) && (adc_wide[7] != state.adc_dst[7]);
    next_state.adc_sum     = adc_wide[7:0];
    next_state.adc_flags.c = adc_wide[8];
    next_state.adc_flags.z = (adc_wide[7:0] == 8'h00);
    next_state.adc_flags.s = adc_wide[7];
    next_state.adc_flags.v = adc_ovf;
    next_state.adc_flags.d = 1'b0;
    next_state.adc_flags.h = adc_low[4];

    next_state.slverr = 1'b0;
    if (wr_en) begin
      unique case (paddr)
        CPUOD_OFF_OPC: begin
          next_state.instr.opcode = cpuod_merge(state.instr.opcode, pwdata[7:0], pstrb[0]);
        end
        CPUOD_OFF_OPND: begin
          next_state.instr.byte1 = cpuod_merge(state.instr.byte1, pwdata[7:0], pstrb[0]);
          next_state.instr.byte2 = cpuod_merge(state.instr.byte2, pwdata[15:8], pstrb[1]);
          next_state.instr.byte3 = cpuod_merge(state.instr.byte3, pwdata[23:16], pstrb[2]);
        end
        CPUOD_OFF_FLAGS: begin
          if (pstrb[0]) begin
            next_state.flags = pwdata[CPUOD_FLAG_C:CPUOD_FLAG_H];
          end
        end
        CPUOD_OFF_PC: begin
          next_state.next_pc[7:0]  = cpuod_merge(state.next_pc[7:0], pwdata[7:0], pstrb[0]);
          next_state.next_pc[15:8] = cpuod_merge(state.next_pc[15:8], pwdata[15:8], pstrb[1]);
        end
        CPUOD_OFF_RP: begin
          next_state.reg_ptr = cpuod_merge(state.reg_ptr, pwdata[7:0], pstrb[0]);
        end
        CPUOD_OFF_BASE: begin
          next_state.base[7:0]  = cpuod_merge(state.base[7:0], pwdata[7:0], pstrb[0]);
          next_state.base[15:8] = cpuod_merge(state.base[15:8], pwdata[15:8], pstrb[1]);
        end
        CPUOD_OFF_ADC: begin
          next_state.adc_dst = cpuod_merge(state.adc_dst, pwdata[7:0], pstrb[0]);
          next_state.adc_src = cpuod_merge(state.adc_src, pwdata[15:8], pstrb[1]);
        end
        CPUOD_OFF_JUMP, CPUOD_OFF_ADDR, CPUOD_OFF_FIELDS: begin
          next_state.slverr = 1'b0;
        end
        default: begin
          next_state.slverr = 1'b1;
        end
      endcase
    end

    next_state.rdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        CPUOD_OFF_OPC:   next_state.rdata = {24'h000000, state.instr.opcode};
        CPUOD_OFF_OPND:  next_state.rdata = {8'h00, state.instr.byte3, state.instr.byte2,
                                             state.instr.byte1};
        CPUOD_OFF_FLAGS: next_state.rdata = {24'h000000, state.flags, 2'b00};
        CPUOD_OFF_PC:    next_state.rdata = {16'h0000, state.next_pc};
        CPUOD_OFF_RP:    next_state.rdata = {24'h000000, state.reg_ptr};
        CPUOD_OFF_BASE:  next_state.rdata = {16'h0000, state.base};
        CPUOD_OFF_JUMP:  next_state.rdata = {14'h0000, state.is_cond, state.taken,
                                             state.target};
        CPUOD_OFF_ADDR:  next_state.rdata = {state.src_reg, state.dst_reg, state.index_addr};
        CPUOD_OFF_ADC:   next_state.rdata = {16'h0000, state.adc_flags, 2'b00,
                                             state.adc_sum};
        CPUOD_OFF_FIELDS: next_state.rdata = {4'h0, state.ext_addr, 3'b000, polarity,
                                              1'b0, bit_number, trap_vector};
        default: begin
          next_state.rdata  = 32'h0000_0000;
          next_state.slverr = 1'b1;
        end
      endcase
    end
    // immediate is readable through the operand register as byte 0
    if (immediate_byte != trap_vector) begin
      next_state.slverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // assertions
  never_jump_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode[7:4] == 4'h0) && $stable(state.instr) |=> !state.taken)
    else $error("never selector took a jump");
  always_jump_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h8D) && $stable(state.instr) |=> state.taken)
    else $error("always selector did not jump");
  signed_less_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h1B) |=> state.taken == $past(sxv))
    else $error("signed less test wrong");
  carry_test_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h7D) |=> state.taken == $past(state.flags.c))
    else $error("carry test wrong");
  zero_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'hED) |=> state.taken == !$past(state.flags.z))
    else $error("nonzero test wrong");
  fallthrough_a: assert property (@(posedge pclk) disable iff (!presetn)
    !next_state.taken |=> state.target == $past(state.next_pc))
    else $error("not taken jump left sequence");
  relative_tgt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h8B) |=> state.target ==
      $past(state.next_pc) + {{8{$past(state.instr.byte1[7])}}, $past(state.instr.byte1)})
    else $error("relative target wrong");
  escape_reg_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.byte1[7:4] == 4'hE) |=> state.src_reg[3:0] == $past(state.instr.byte1[3:0]))
    else $error("escaped register not decoded");
  adc_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> state.adc_sum == 8'($past(state.adc_dst) + $past(state.adc_src) +
                                  8'($past(state.flags.c))) && !state.adc_flags.d)
    else $error("add with carry wrong");

  // one check per remaining selector code; the always form keeps flags from its own cycle

  signed_le_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h2D) |=> state.taken == $past(state.flags.z | sxv))
    else $error("signed less or equal test wrong");

  signed_ge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h9D) |=> state.taken == !$past(sxv))
    else $error("signed greater or equal test wrong");

  signed_gt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'hAB) |=> state.taken == !$past(state.flags.z | sxv))
    else $error("signed greater test wrong");

  unsigned_le_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h3D) |=> state.taken == $past(state.flags.c | state.flags.z))
    else $error("unsigned less or equal test wrong");

  unsigned_gt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'hBD) |=> state.taken == !$past(state.flags.c | state.flags.z))
    else $error("unsigned greater test wrong");

  carry_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'hFB) |=> state.taken == !$past(state.flags.c))
    else $error("no carry test wrong");

  ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h4D) |=> state.taken == $past(state.flags.v))
    else $error("overflow test wrong");

  neg_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h5B) |=> state.taken == $past(state.flags.s))
    else $error("negative test wrong");

  zero_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h6D) |=> state.taken == $past(state.flags.z))
    else $error("zero test wrong");

  ovf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'hCB) |=> state.taken == !$past(state.flags.v))
    else $error("overflow clear test wrong");

  pos_test_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'hDD) |=> state.taken == !$past(state.flags.s))
    else $error("positive test wrong");

  not_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode[3:0] != 4'hB) && (state.instr.opcode[3:0] != 4'hD) |=> !state.taken)
    else $error("plain opcode took a jump");

  direct_tgt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h8D) |=>
      state.target == {$past(state.instr.byte1), $past(state.instr.byte2)})
    else $error("direct target wrong");

  // operand bytes and derived addresses

  add_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h04) && (state.instr.byte1[7:4] != 4'hE) |=>
      state.src_reg == $past(state.instr.byte1))
    else $error("add source byte order wrong");

  add_dst_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.opcode == 8'h04) && (state.instr.byte2[7:4] != 4'hE) |=>
      state.dst_reg == $past(state.instr.byte2))
    else $error("add destination byte order wrong");

  plain_reg_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.byte1[7:4] != 4'hE) |=> state.src_reg == $past(state.instr.byte1))
    else $error("plain register altered");

  escape_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state.instr.byte1[7:4] == 4'hE) |=> state.src_reg[7:4] == $past(state.reg_ptr[7:4]))
    else $error("escaped register bank wrong");

  ext_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> state.ext_addr == {$past(state.instr.byte1[3:0]), $past(state.instr.byte2)})
    else $error("extended address wrong");

  index_even_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> state.index_addr == {$past(state.base[15:1]), 1'b0} +
      {{8{$past(state.instr.byte3[7])}}, $past(state.instr.byte3)})
    else $error("indexed location wrong");

  bit_num_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (paddr == CPUOD_OFF_FIELDS) |=> state.rdata[10:8] == $past(state.instr.byte1[3:1]))
    else $error("bit number field wrong");

  polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (paddr == CPUOD_OFF_FIELDS) |=> state.rdata[12] == $past(state.instr.byte1[7]))
    else $error("polarity field wrong");

  imm_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (paddr == CPUOD_OFF_FIELDS) |=> state.rdata[7:0] == $past(state.instr.byte1))
    else $error("immediate byte field wrong");

  // add with carry flags; carry and half carry worked out independently, zero, sign and overflow checked against the registered sum

  adc_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> {state.adc_flags.c, state.adc_sum} == 9'($past(state.adc_dst)) +
      9'($past(state.adc_src)) + 9'($past(state.flags.c)))
    else $error("add with carry carry out wrong");

  adc_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> state.adc_flags.z == (state.adc_sum == 8'h00) && state.adc_flags.s == state.adc_sum[7])
    else $error("add with carry zero or sign wrong");

  adc_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> state.adc_flags.h == (5'($past(state.adc_dst[3:0])) +
      5'($past(state.adc_src[3:0])) + 5'($past(state.flags.c)) > 5'h0F))
    else $error("add with carry half carry wrong");

  adc_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> state.adc_flags.v == (($past(state.adc_dst[7]) == $past(state.adc_src[7])) &&
      (state.adc_sum[7] != $past(state.adc_dst[7]))))
    else $error("add with carry overflow wrong");

endmodule : cpuod_decode

/* File: bench/cpuod_prog_mem.sv */
// program memory model that hands instruction words to the bench
module cpuod_prog_mem
  import cpuod_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         load_en,
  input  wire logic   [7:0] load_addr,
  input  wire cpuod_instr_t load_word,
  input  wire logic   [7:0] fetch_addr,
  output cpuod_instr_t      fetch_word
);
  timeunit 1ns;
  timeprecision 1ps;
  cpuod_instr_t mem [256];
  // word lands one edge after the load; fetch is combinational
  always @(posedge pclk) begin
    if (load_en) begin
      mem[load_addr] <= load_word;
    end
  end
  assign fetch_word = mem[fetch_addr];
endmodule : cpuod_prog_mem

/* File: bench/cpu_operand_and_condition_decode_bench.sv */
// self-checking bench for the operand and condition decoder
module cpu_operand_and_condition_decode_bench
  import cpuod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [31:0] d; logic [31:0] m; logic e; } cpuod_note_t;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, jump_taken, load_en;
  logic         rd_seen = 1'b0;
  logic         tk, co, h, v, c;
  logic  [11:0] paddr;
  logic  [31:0] pwdata, prdata;
  logic   [3:0] pstrb;
  logic  [15:0] jump_target, tg, pc, bs, idx;
  logic   [7:0] load_addr, rp, src, d, s, sum;
  logic   [5:0] fl;
  cpuod_instr_t load_word, fetch_word, ins, f;
  cpuod_note_t  notes[$];
  int           fails, check_count;

  cpuod_decode i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .jump_taken(jump_taken), .jump_target(jump_target));
  cpuod_prog_mem i_mem (.pclk(pclk), .load_en(load_en), .load_addr(load_addr),
    .load_word(load_word), .fetch_addr(load_addr), .fetch_word(fetch_word));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // idle edge first, so a release and the next setup never share a time step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] em, input logic ee);
    notes.push_back('{ed, em, ee});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task fetch(input cpuod_instr_t w, output cpuod_instr_t fw);
    @(posedge pclk);
    load_en <= 1'b1;
    load_addr <= w.byte3;
    load_word <= w;
    @(posedge pclk);
    load_en <= 1'b0;
    @(posedge pclk);
    fw = fetch_word;
  endtask : fetch

  function automatic logic cc_true(input logic [3:0] cc, input logic fc, fz, fs, fv);
    logic t;
    case (cc[2:0])
      3'h0: t = 1'b0;
      3'h1: t = fs ^ fv;
      3'h2: t = fz | (fs ^ fv);
      3'h3: t = fc | fz;
      3'h4: t = fv;
      3'h5: t = fs;
      3'h6: t = fz;
      default: t = fc;
    endcase
    return t ^ cc[3];
  endfunction : cc_true

  // register reads answer one edge after the access edge
  always @(posedge pclk) begin
    cpuod_note_t n;
    if (rd_seen && notes.size() > 0) begin
      n = notes.pop_front();
      check(prdata & n.m, n.d);
      check({31'h0, pslverr}, {31'h0, n.e});
    end
    rd_seen <= presetn && psel && penable && !pwrite && pready;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, load_en, presetn} = 5'h00;
    {paddr, pwdata, load_addr, load_word} = '0;
    pstrb = 4'hF;
    void'($urandom(9));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, jump_taken}, 32'h0);
    rd(CPUOD_OFF_JUMP, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(CPUOD_OFF_FLAGS, 32'h0, 32'hFF, 1'b0);
    for (int i = 0; i < 128; i++) begin
      ins = 32'($urandom);
      ins.opcode = {i[3:0], i[4] ? CPUOD_OPC_JR_LO : CPUOD_OPC_JP_LO};
      if (i[6:5] == 2'h0) ins.byte1 = i[0] ? 8'h80 : 8'h7F;
      fetch(ins, f);
      fl = 6'($urandom);
      pc = 16'($urandom);
      apb(1'b1, CPUOD_OFF_OPC, {24'h0, f.opcode});
      apb(1'b1, CPUOD_OFF_OPND, {8'h0, f.byte3, f.byte2, f.byte1});
      apb(1'b1, CPUOD_OFF_FLAGS, {24'h0, fl, 2'b00});
      apb(1'b1, CPUOD_OFF_PC, {16'h0, pc});
      tk = cc_true(f.opcode[7:4], fl[5], fl[4], fl[3], fl[2]);
      tg = !tk ? pc : i[4] ? pc + {{8{f.byte1[7]}}, f.byte1} : {f.byte1, f.byte2};
      rd(CPUOD_OFF_JUMP, {14'h0, 1'b1, tk, tg}, 32'h3_FFFF, 1'b0);
      check({31'h0, jump_taken}, {31'h0, tk});
      check({16'h0, jump_target}, {16'h0, tg});
    end
    for (int i = 0; i < 16; i++) begin
      ins = 32'($urandom);
      ins.opcode = CPUOD_OPC_ADD_RR;
      if (i[0]) ins.byte1[7:4] = CPUOD_ESC_NIBBLE;
      ins.byte2[7] = 1'b0;
      if (i < 4) ins.byte3 = i[1] ? 8'h80 : 8'h7F;
      fetch(ins, f);
      rp = 8'($urandom);
      bs = 16'($urandom);
      apb(1'b1, CPUOD_OFF_OPC, {24'h0, f.opcode});
      apb(1'b1, CPUOD_OFF_OPND, {8'h0, f.byte3, f.byte2, f.byte1});
      apb(1'b1, CPUOD_OFF_RP, {24'h0, rp});
      apb(1'b1, CPUOD_OFF_BASE, {16'h0, bs});
      src = (f.byte1[7:4] == CPUOD_ESC_NIBBLE) ? {rp[7:4], f.byte1[3:0]} : f.byte1;
      idx = {bs[15:1], 1'b0} + {{8{f.byte3[7]}}, f.byte3};
      rd(CPUOD_OFF_ADDR, {src, f.byte2, idx}, 32'hFFFF_FFFF, 1'b0);
      rd(CPUOD_OFF_FIELDS, {4'h0, f.byte1[3:0], f.byte2, 3'h0, f.byte1[7], 1'b0, f.byte1[3:1],
        f.byte1}, 32'h0FFF_17FF, 1'b0);
      rd(CPUOD_OFF_JUMP, 32'h0, 32'h3_0000, 1'b0);
    end
    for (int i = 0; i < 16; i++) begin
      {d, s, c} = 17'($urandom);
      if (i == 0) {d, s, c} = {8'hFF, 8'h00, 1'b1};
      if (i == 1) {d, s, c} = {8'h08, 8'h08, 1'b0};
      apb(1'b1, CPUOD_OFF_OPC, {24'h0, i[0] ? CPUOD_OPC_ADC_RIR : CPUOD_OPC_ADC_RR});
      apb(1'b1, CPUOD_OFF_FLAGS, {24'h0, c, 7'h0});
      apb(1'b1, CPUOD_OFF_ADC, {16'h0, s, d});
      {co, sum} = {1'b0, d} + {1'b0, s} + {8'h0, c};
      h = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, c}) > 5'hF;
      v = (d[7] == s[7]) && (sum[7] != d[7]);
      rd(CPUOD_OFF_ADC, {16'h0, co, sum == 8'h0, sum[7], v, 1'b0, h, 2'b00, sum},
        32'hFCFF, 1'b0);
    end
    // unmapped place answers with the error flag and no data check
    rd(12'h0FC, 32'h0, 32'h0, 1'b1);
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule : cpu_operand_and_condition_decode_bench
